// ### hdl/step_sequence_engine.sv
// Implementation choices: the placing of the registers and the strobed register port.
`timescale 1ns/10ps
`default_nettype none
module step_sequence_engine (
  // Clock and reset
  input  wire logic        sys_clk_i,
  input  wire logic        arst_n_i,
  // Register port
  input  wire logic [7:0]  reg_addr_i,
  input  wire logic [31:0] reg_wdata_i,
  input  wire logic        reg_wr_i,
  input  wire logic        reg_rd_i,
  output logic      [31:0] reg_rdata_o,
  // Trigger inputs
  input  wire logic        trig_a_i,
  input  wire logic        trig_b_i,
  // Source settings
  output logic      [12:0] step_frequency_o,
  output logic      [4:0]  wave_o,
  output logic      [21:0] phase_o,
  output logic      [7:0]  step_num_o,
  // Marker lines
  output logic             marker_out_low_o,
  output logic             marker_out_high_o
);
  ////////////////////////////////////////////////////////////////////////////
  logic [1:0] rst_q;
  logic       rst_n;
  always_ff @(posedge sys_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i) rst_q <= 2'h0;
    else rst_q <= {rst_q[0], 1'b1};
  end
  assign rst_n = rst_q[1];

  // Triggers: three flops, accepted once the last two agree
  logic [1:0] trig_raw;
  logic [1:0] trig_evt;
  assign trig_raw = {trig_b_i, trig_a_i};
  for (genvar g = 0; g < 2; g++)
  begin : g_trig
    logic [2:0] sy;
    logic       lvl;
    always_ff @(posedge sys_clk_i or negedge rst_n)
    begin
      if (!rst_n) {sy, lvl} <= 4'h0;
      else
      begin
        sy <= {sy[1:0], trig_raw[g]};
        if (sy[1] == sy[2]) lvl <= sy[1];
      end
    end
    assign trig_evt[g] = sy[1] & sy[2] & ~lvl;
  end

  ////////////////////////////////////////////////////////////////////////////
  step_seq_pkg::state_t state;
  logic [7:0]  cur_step;
  logic [7:0]  step_sel;
  logic [7:0]  clr_idx;
  logic [31:0] mem [0:3][0:255];
  logic [31:0] cw  [0:3];
  logic [31:0] wr_word;
  logic [1:0]  word_idx;
  logic        wr_ctrl;
  logic        word_wr;
  assign wr_ctrl  = reg_wr_i && reg_addr_i == step_seq_pkg::REG_CTRL;
  assign word_idx = 2'((reg_addr_i - step_seq_pkg::REG_WORD0) >> 2);
  // Step zero is not an entry, writes to it are dropped
  assign word_wr  = reg_wr_i && step_sel != 8'h00 &&
                    reg_addr_i >= step_seq_pkg::REG_WORD0 &&
                    reg_addr_i <= step_seq_pkg::REG_WORD3 &&
                    reg_addr_i[1:0] == 2'h0;
  logic cmd_start, cmd_stop, cmd_hold, cmd_clear;
  logic [1:0] sw_br;
  assign cmd_start = wr_ctrl & reg_wdata_i[step_seq_pkg::CMD_START];
  assign cmd_stop  = wr_ctrl & reg_wdata_i[step_seq_pkg::CMD_STOP];
  assign cmd_hold  = wr_ctrl & reg_wdata_i[step_seq_pkg::CMD_HOLD];
  assign cmd_clear = wr_ctrl & reg_wdata_i[step_seq_pkg::CMD_CLEAR];
  assign sw_br = {wr_ctrl & reg_wdata_i[step_seq_pkg::CMD_BRB],
                  wr_ctrl & reg_wdata_i[step_seq_pkg::CMD_BRA]};

  // Out-of-range settings are clamped so the sequencer never sees them
  logic [12:0] w_step_frequency;
  logic [4:0]  w_wave;
  logic [11:0] w_ph, w_eph;
  logic [23:0] w_dur;
  logic [9:0]  w_jc;
  assign w_step_frequency = reg_wdata_i[step_seq_pkg::STEP_FREQUENCY_LSB +: step_seq_pkg::STEP_FREQUENCY_W];
  assign w_wave = reg_wdata_i[step_seq_pkg::WAVE_LSB +: step_seq_pkg::WAVE_W];
  assign w_ph   = reg_wdata_i[step_seq_pkg::PHASE_LSB +: step_seq_pkg::ANG_W];
  assign w_eph  = reg_wdata_i[step_seq_pkg::EPH_LSB +: step_seq_pkg::ANG_W];
  assign w_dur  = reg_wdata_i[step_seq_pkg::DUR_LSB +: step_seq_pkg::DUR_W];
  assign w_jc   = reg_wdata_i[step_seq_pkg::JC_LSB +: step_seq_pkg::JC_W];
  always_comb
  begin
    wr_word = reg_wdata_i;
    unique case (word_idx)
      2'h0:
      begin
        wr_word[step_seq_pkg::STEP_FREQUENCY_LSB +: step_seq_pkg::STEP_FREQUENCY_W] =
          (w_step_frequency < step_seq_pkg::STEP_FREQUENCY_MIN) ? step_seq_pkg::STEP_FREQUENCY_MIN :
          (w_step_frequency > step_seq_pkg::STEP_FREQUENCY_MAX) ? step_seq_pkg::STEP_FREQUENCY_MAX :
          w_step_frequency;
        wr_word[step_seq_pkg::WAVE_LSB +: step_seq_pkg::WAVE_W] =
          (w_wave > step_seq_pkg::WAVE_MAX) ? step_seq_pkg::WAVE_MAX :
          w_wave;
      end
      2'h1:
      begin
        wr_word[step_seq_pkg::PHASE_LSB +: step_seq_pkg::ANG_W] =
          (w_ph > step_seq_pkg::ANG_MAX) ? step_seq_pkg::ANG_MAX : w_ph;
        wr_word[step_seq_pkg::EPH_LSB +: step_seq_pkg::ANG_W] =
          (w_eph > step_seq_pkg::ANG_MAX) ? step_seq_pkg::ANG_MAX : w_eph;
      end
      2'h2:
        wr_word = {8'h00,
          (w_dur < step_seq_pkg::DUR_MIN) ? step_seq_pkg::DUR_MIN :
          (w_dur > step_seq_pkg::DUR_MAX) ? step_seq_pkg::DUR_MAX :
          w_dur};
      2'h3:
        wr_word[step_seq_pkg::JC_LSB +: step_seq_pkg::JC_W] =
          (w_jc > step_seq_pkg::JC_MAX) ? step_seq_pkg::JC_MAX : w_jc;
    endcase
  end

  // Clear walks all entries, one per cycle, and locks out bus writes
  always_ff @(posedge sys_clk_i)
  begin
    if (state == step_seq_pkg::ST_CLEAR)
    begin
      mem[0][clr_idx] <= {19'h00000, step_seq_pkg::DEF_STEP_FREQUENCY};
      mem[1][clr_idx] <= 32'h00000000;
      mem[2][clr_idx] <= {8'h00, step_seq_pkg::DEF_DUR};
      mem[3][clr_idx] <= 32'h00000000;
    end
    else if (word_wr) mem[word_idx][step_sel] <= wr_word;
    for (int w = 0; w < 4; w++) cw[w] <= mem[w][cur_step];
  end

  ////////////////////////////////////////////////////////////////////////////
  logic [12:0] f_step_frequency;
  logic [1:0]  f_fop, f_mcode, f_eact;
  logic [4:0]  f_wave;
  logic        f_wop, f_mop, f_epen, f_pop;
  logic [11:0] f_phase, f_eph;
  logic [23:0] f_dur;
  logic [7:0]  f_jt, f_bra, f_brb;
  logic [9:0]  f_jc;
  assign f_step_frequency  = cw[0][step_seq_pkg::STEP_FREQUENCY_LSB +: step_seq_pkg::STEP_FREQUENCY_W];
  assign f_fop   = cw[0][step_seq_pkg::FOP_LSB +: 2];
  assign f_wave  = cw[0][step_seq_pkg::WAVE_LSB +: step_seq_pkg::WAVE_W];
  assign f_wop   = cw[0][step_seq_pkg::WOP_BIT];
  assign f_mop   = cw[0][step_seq_pkg::MOP_BIT];
  assign f_mcode = cw[0][step_seq_pkg::MCODE_LSB +: 2];
  assign f_epen  = cw[0][step_seq_pkg::EPEN_BIT];
  assign f_eact  = cw[0][step_seq_pkg::EACT_LSB +: 2];
  assign f_pop   = cw[0][step_seq_pkg::POP_BIT];
  assign f_phase = cw[1][step_seq_pkg::PHASE_LSB +: step_seq_pkg::ANG_W];
  assign f_eph   = cw[1][step_seq_pkg::EPH_LSB +: step_seq_pkg::ANG_W];
  assign f_brb   = cw[1][step_seq_pkg::BRB_LSB +: step_seq_pkg::STEP_W];
  assign f_dur   = cw[2][step_seq_pkg::DUR_LSB +: step_seq_pkg::DUR_W];
  assign f_jt    = cw[3][step_seq_pkg::JT_LSB +: step_seq_pkg::STEP_W];
  assign f_jc    = cw[3][step_seq_pkg::JC_LSB +: step_seq_pkg::JC_W];
  assign f_bra   = cw[3][step_seq_pkg::BRA_LSB +: step_seq_pkg::STEP_W];

  logic [12:0] step_frequency_out, ramp_tgt, div_quo, div_num, ramp_stp;
  logic [4:0]  wave_out;
  logic [1:0]  marker;
  logic [21:0] phase_acc, ph_sum, ph_next, ph_tgt;
  logic [23:0] dur, elapsed, div_rem, ramp_acc;
  logic [24:0] div_sh, ramp_sum;
  logic [11:0] tick_cnt;
  logic [3:0]  div_cnt;
  logic [7:0]  owner;
  logic [9:0]  remaining;
  logic        ramping, ramp_dn, time_done, resume_fetch;
  logic        tick, last_tick, ph_wrap, crossed, end_now, take_end;
  logic        do_jump, seq_over, br_hit, br_any;
  logic [7:0]  br_tgt, next_step;
  assign tick      = state == step_seq_pkg::ST_RUN &&
                     tick_cnt == step_seq_pkg::TICK_LAST;
  assign last_tick = tick && !time_done && elapsed + 24'h1 == dur;
  assign ph_sum  = phase_acc + {3'h0, step_frequency_out} * {16'h0, step_seq_pkg::PH_ADV};
  assign ph_wrap = ph_sum >= step_seq_pkg::PH_MOD;
  assign ph_next = ph_wrap ? ph_sum - step_seq_pkg::PH_MOD : ph_sum;
  assign ph_tgt  = {10'h000, f_eph} * {12'h000, step_seq_pkg::PH_SCALE};
  assign crossed = ph_wrap ? (ph_next >= ph_tgt || phase_acc < ph_tgt)
                           : (phase_acc < ph_tgt && ph_sum >= ph_tgt);
  // With end phase on, the step ends at the first crossing on or after its last tick
  assign end_now = f_epen ? tick && (time_done || last_tick) && crossed
                          : last_tick;
  assign br_any   = |(trig_evt | sw_br);
  assign br_tgt   = (trig_evt[0] | sw_br[0]) && f_bra != 8'h00 ? f_bra : f_brb;
  assign br_hit   = state == step_seq_pkg::ST_RUN && br_any &&
                    br_tgt != 8'h00 &&
                    ((trig_evt[0] | sw_br[0]) && f_bra != 8'h00 ||
                     (trig_evt[1] | sw_br[1]) && f_brb != 8'h00);
  assign take_end = end_now && !cmd_stop && !cmd_hold && !cmd_clear && !br_hit;
  assign do_jump  = f_jt != 8'h00 && (f_jc == 10'h000 || owner != cur_step ||
                    remaining != 10'h000);
  assign seq_over  = !do_jump && cur_step == step_seq_pkg::STEP_LAST;
  assign next_step = do_jump ? f_jt : cur_step + 8'h01;
  assign ramp_sum  = {1'b0, ramp_acc} + {12'h000, div_rem[12:0]};
  assign ramp_stp  = div_quo + {12'h000, ramp_sum >= {1'b0, dur}};
  assign div_sh    = {div_rem, div_num[12]};

  always_ff @(posedge sys_clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state <= step_seq_pkg::ST_IDLE;
      {cur_step, clr_idx, owner, remaining, marker} <= 36'h000000000;
      {dur, elapsed, div_rem, ramp_acc, tick_cnt} <= 108'h0;
      {div_quo, div_num, ramp_tgt, div_cnt} <= 43'h0;
      {phase_acc, wave_out} <= 27'h0000000;
      step_frequency_out <= step_seq_pkg::DEF_STEP_FREQUENCY;
      {ramping, ramp_dn, time_done, resume_fetch} <= 4'h0;
    end
    else if (cmd_clear)
    begin
      state   <= step_seq_pkg::ST_CLEAR;
      clr_idx <= 8'h00;
      marker  <= 2'h0;
    end
    else if (cmd_stop && state != step_seq_pkg::ST_CLEAR)
    begin
      state  <= step_seq_pkg::ST_IDLE;
      marker <= 2'h0;
    end
    else
    begin
      unique case (state)
        step_seq_pkg::ST_IDLE:
          if (cmd_start)
          begin
            cur_step <= step_seq_pkg::STEP_FIRST;
            owner    <= 8'h00;
            state    <= step_seq_pkg::ST_FETCH;
          end
        step_seq_pkg::ST_CLEAR:
        begin
          clr_idx <= clr_idx + 8'h01;
          if (clr_idx == step_seq_pkg::STEP_LAST) state <= step_seq_pkg::ST_IDLE;
        end
        step_seq_pkg::ST_FETCH: state <= step_seq_pkg::ST_APPLY;
        step_seq_pkg::ST_APPLY:
        begin
          {elapsed, tick_cnt, ramp_acc} <= 60'h0;
          dur       <= f_dur;
          time_done <= 1'b0;
          ramp_tgt  <= f_step_frequency;
          ramp_dn   <= f_step_frequency < step_frequency_out;
          ramping   <= f_fop == step_seq_pkg::OP_RAMP;
          if (f_fop == step_seq_pkg::OP_APPLY) step_frequency_out <= f_step_frequency;
          if (!f_wop) wave_out <= f_wave;
          if (!f_pop) phase_acc <= {10'h000, f_phase} *
                                   {12'h000, step_seq_pkg::PH_SCALE};
          if (!f_mop) marker <= f_mcode;
          // Split the ramp distance into per-tick quotient and remainder
          div_num <= f_step_frequency < step_frequency_out ? step_frequency_out - f_step_frequency : f_step_frequency - step_frequency_out;
          div_rem <= 24'h000000;
          div_cnt <= step_seq_pkg::DIV_STEPS;
          state   <= f_fop == step_seq_pkg::OP_RAMP ? step_seq_pkg::ST_DIVIDE
                                                    : step_seq_pkg::ST_RUN;
        end
        step_seq_pkg::ST_DIVIDE:
        begin
          div_rem <= div_sh >= {1'b0, dur} ? 24'(div_sh - {1'b0, dur})
                                           : div_sh[23:0];
          div_quo <= {div_quo[11:0], div_sh >= {1'b0, dur}};
          div_num <= {div_num[11:0], 1'b0};
          div_cnt <= div_cnt - 4'h1;
          if (div_cnt == 4'h1) state <= step_seq_pkg::ST_RUN;
        end
        step_seq_pkg::ST_RUN:
        begin
          tick_cnt <= tick ? 12'h000 : tick_cnt + 12'h001;
          if (tick)
          begin
            phase_acc <= ph_next;
            if (!time_done) elapsed <= elapsed + 24'h1;
            if (last_tick) time_done <= 1'b1;
            // Remainder carries make the last tick land on the target
            if (ramping && !time_done)
            begin
              step_frequency_out <= ramp_dn ? step_frequency_out - ramp_stp
                                  : step_frequency_out + ramp_stp;
              ramp_acc <= ramp_sum >= {1'b0, dur} ? 24'(ramp_sum - {1'b0, dur})
                                                  : ramp_sum[23:0];
            end
          end
          if (cmd_hold)
          begin
            state        <= step_seq_pkg::ST_HOLD;
            resume_fetch <= 1'b0;
          end
          else if (br_hit)
          begin
            cur_step <= br_tgt;
            owner    <= 8'h00;
            state    <= step_seq_pkg::ST_FETCH;
          end
          else if (take_end)
          begin
            if (f_jt != 8'h00 && f_jc != 10'h000)
            begin
              if (owner != cur_step)
              begin
                owner     <= cur_step;
                remaining <= f_jc - 10'h001;
              end
              else if (remaining != 10'h000) remaining <= remaining - 10'h001;
              else owner <= 8'h00;
            end
            cur_step <= next_step;
            if (f_eact == step_seq_pkg::END_IDLE || seq_over)
            begin
              state  <= step_seq_pkg::ST_IDLE;
              marker <= 2'h0;
            end
            else if (f_eact == step_seq_pkg::END_HOLD)
            begin
              state        <= step_seq_pkg::ST_HOLD;
              resume_fetch <= 1'b1;
            end
            else state <= step_seq_pkg::ST_FETCH;
          end
        end
        step_seq_pkg::ST_HOLD:
          if (cmd_start)
            state <= resume_fetch ? step_seq_pkg::ST_FETCH
                                  : step_seq_pkg::ST_RUN;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge sys_clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      step_sel    <= 8'h00;
      reg_rdata_o <= 32'h00000000;
    end
    else
    begin
      if (reg_wr_i && reg_addr_i == step_seq_pkg::REG_STEP_SEL)
        step_sel <= reg_wdata_i[7:0];
      if (reg_rd_i)
        reg_rdata_o <= (reg_addr_i == step_seq_pkg::REG_STATUS) ?
                         {16'h0000, time_done, state, cur_step} :
                       (reg_addr_i == step_seq_pkg::REG_STEP_SEL) ?
                         {24'h000000, step_sel} :
                       (reg_addr_i == step_seq_pkg::REG_OUT_STEP_FREQUENCY) ?
                         {19'h00000, step_frequency_out} :
                       (word_wr || (reg_addr_i >= step_seq_pkg::REG_WORD0 &&
                        reg_addr_i <= step_seq_pkg::REG_WORD3 &&
                        reg_addr_i[1:0] == 2'h0)) ?
                         mem[word_idx][step_sel] : 32'h00000000;
    end
  end
  assign step_frequency_o  = step_frequency_out;
  assign wave_o            = wave_out;
  assign phase_o           = phase_acc;
  assign step_num_o        = cur_step;
  assign marker_out_low_o  = marker[0];
  assign marker_out_high_o = marker[1];

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n);
  AST_IDLE_MARK: assert property (state == step_seq_pkg::ST_IDLE |->
    marker == 2'h0) else $error("marker not low in idle");
  AST_MARK_SET: assert property (state == step_seq_pkg::ST_APPLY && !f_mop
    && !cmd_clear && !cmd_stop |=> marker == $past(f_mcode))
    else $error("marker code not applied");
  AST_MARK_KEEP: assert property (state == step_seq_pkg::ST_APPLY && f_mop
    && !cmd_clear && !cmd_stop |=> $stable(marker))
    else $error("marker not carried");
  AST_TICK: assert property (tick |=> !tick [*8])
    else $error("ticks too close");
  AST_RAMP: assert property (last_tick && ramping && take_end |=>
    step_frequency_out == $past(ramp_tgt)) else $error("ramp missed target");
  AST_STEP_FREQUENCY: assert property (state == step_seq_pkg::ST_RUN |->
    step_frequency_out >= step_seq_pkg::STEP_FREQUENCY_MIN && step_frequency_out <= step_seq_pkg::STEP_FREQUENCY_MAX)
    else $error("frequency out of range");
  AST_PHASE: assert property (phase_acc < step_seq_pkg::PH_MOD)
    else $error("phase out of range");
  AST_JUMP: assert property (take_end && do_jump &&
    f_eact == step_seq_pkg::END_PROCEED |=> cur_step == $past(f_jt) &&
    state == step_seq_pkg::ST_FETCH) else $error("jump not taken");
  AST_END_IDLE: assert property (take_end && f_eact == step_seq_pkg::END_IDLE
    |=> state == step_seq_pkg::ST_IDLE) else $error("end action idle lost");
  AST_BR_IGN: assert property (state == step_seq_pkg::ST_RUN && !br_hit &&
    !take_end |=> $stable(cur_step)) else $error("ignored branch moved step");
  AST_CLEAR: assert property (state == step_seq_pkg::ST_CLEAR && !cmd_clear &&
    clr_idx == step_seq_pkg::STEP_LAST |=> state == step_seq_pkg::ST_IDLE)
    else $error("clear did not finish");
  AST_END_TIME: assert property (take_end && !f_epen |-> last_tick)
    else $error("step ended off time");
  AST_STEP_NZ: assert property (state == step_seq_pkg::ST_RUN |->
    cur_step != 8'h00) else $error("step zero running");
  AST_JC: assert property (remaining <= step_seq_pkg::JC_MAX)
    else $error("jump count out of range");
endmodule // step_sequence_engine
`default_nettype wire

// ### hdl/step_seq_pkg.sv
package step_seq_pkg;
  // Register map, byte addresses
  localparam logic [7:0] REG_CTRL     = 8'h00;
  localparam logic [7:0] REG_STATUS   = 8'h04;
  localparam logic [7:0] REG_STEP_SEL = 8'h08;
  localparam logic [7:0] REG_WORD0    = 8'h0c;
  localparam logic [7:0] REG_WORD3    = 8'h18;
  localparam logic [7:0] REG_OUT_STEP_FREQUENCY = 8'h1c;
  // Control command bits
  localparam int CMD_START = 0;
  localparam int CMD_STOP  = 1;
  localparam int CMD_HOLD  = 2;
  localparam int CMD_BRA   = 3;
  localparam int CMD_BRB   = 4;
  localparam int CMD_CLEAR = 5;
  // Word 0 fields
  localparam int STEP_FREQUENCY_LSB  = 0;
  localparam int STEP_FREQUENCY_W    = 13;
  localparam int FOP_LSB   = 13;
  localparam int WAVE_LSB  = 15;
  localparam int WAVE_W    = 5;
  localparam int WOP_BIT   = 20;
  localparam int MOP_BIT   = 21;
  localparam int MCODE_LSB = 22;
  localparam int EPEN_BIT  = 24;
  localparam int EACT_LSB  = 25;
  localparam int POP_BIT   = 27;
  // Word 1, 2 and 3 fields
  localparam int ANG_W     = 12;
  localparam int PHASE_LSB = 0;
  localparam int EPH_LSB   = 12;
  localparam int BRB_LSB   = 24;
  localparam int DUR_LSB   = 0;
  localparam int DUR_W     = 24;
  localparam int STEP_W    = 8;
  localparam int JT_LSB    = 0;
  localparam int JC_LSB    = 8;
  localparam int JC_W      = 10;
  localparam int BRA_LSB   = 18;
  // Operation and end action codes
  localparam logic [1:0] OP_APPLY    = 2'h0;
  localparam logic [1:0] OP_RAMP     = 2'h2;
  localparam logic [1:0] END_PROCEED = 2'h0;
  localparam logic [1:0] END_IDLE    = 2'h1;
  localparam logic [1:0] END_HOLD    = 2'h2;
  // Limits and defaults
  localparam logic [12:0] STEP_FREQUENCY_MIN = 13'h00a;
  localparam logic [12:0] STEP_FREQUENCY_MAX = 13'h157c;
  localparam logic [12:0] DEF_STEP_FREQUENCY = 13'h1f4;
  localparam logic [4:0]  WAVE_MAX = 5'h11;
  localparam logic [11:0] ANG_MAX  = 12'he0f;
  localparam logic [23:0] DUR_MIN  = 24'h000001;
  localparam logic [23:0] DUR_MAX  = 24'h98967f;
  localparam logic [23:0] DEF_DUR  = 24'h002710;
  localparam logic [9:0]  JC_MAX   = 10'h3e7;
  localparam logic [7:0]  STEP_FIRST = 8'h01;
  localparam logic [7:0]  STEP_LAST  = 8'hff;
  // Timing
  localparam int TICK_TIME_NS = 100000;
  localparam int CLK_PERIOD_NS = 40;
  localparam int TICK_CYC = (TICK_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [11:0] TICK_LAST = 12'(TICK_CYC - 1);
  localparam logic [3:0]  DIV_STEPS = 4'hd;
  // Phase accumulator in 0.0001 degree units
  localparam logic [21:0] PH_MOD   = 22'h36ee80;
  localparam logic [9:0]  PH_SCALE = 10'h3e8;
  localparam logic [5:0]  PH_ADV   = 6'h24;
  typedef enum logic [6:0] {
    ST_IDLE   = 7'h01,
    ST_FETCH  = 7'h02,
    ST_APPLY  = 7'h04,
    ST_DIVIDE = 7'h08,
    ST_RUN    = 7'h10,
    ST_HOLD   = 7'h20,
    ST_CLEAR  = 7'h40
  } state_t;
endpackage

// ### verif/trig_source.sv
`timescale 1ns/10ps
`default_nettype none
module trig_source (
  // Clock
  input  wire logic sys_clk_i,
  // Bench requests
  input  wire logic fire_a_i,
  input  wire logic fire_b_i,
  // Trigger lines
  output logic      trig_a_o,
  output logic      trig_b_o
);
  // Registered so edges never land on the sampling edge
  always_ff @(posedge sys_clk_i)
  begin
    trig_a_o <= fire_a_i;
    trig_b_o <= fire_b_i;
  end
endmodule // trig_source
`default_nettype wire

// ### verif/tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  logic        sys_clk_i = 1'b0;
  logic        arst_n_i = 1'b0;
  logic [7:0]  reg_addr_i = 8'h00;
  logic [31:0] reg_wdata_i = 32'h0;
  logic        reg_wr_i = 1'b0;
  logic        reg_rd_i = 1'b0;
  logic        fire_a = 1'b0;
  logic        fire_b = 1'b0;
  logic [31:0] reg_rdata_o, rd, seed = 32'hec816354;
  logic        trig_a_i, trig_b_i, m_lo, m_hi;
  logic [12:0] frq, f2, step_frequency_o;
  logic [11:0] ang;
  logic [4:0]  wave_o;
  logic [21:0] phase_o;
  logic [7:0]  step_num_o;
  int          failures = 0;
  int          total_checks = 0;
  always #20 sys_clk_i = ~sys_clk_i;
  step_sequence_engine i_step_sequence_engine (.sys_clk_i(sys_clk_i),
    .arst_n_i(arst_n_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
    .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
    .trig_a_i(trig_a_i), .trig_b_i(trig_b_i),
    .step_frequency_o(step_frequency_o), .wave_o(wave_o), .phase_o(phase_o),
    .step_num_o(step_num_o), .marker_out_low_o(m_lo),
    .marker_out_high_o(m_hi));
  trig_source i_trig_source (.sys_clk_i(sys_clk_i), .fire_a_i(fire_a),
    .fire_b_i(fire_b), .trig_a_o(trig_a_i), .trig_b_o(trig_b_i));
  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  // Expected stored frequency after the device clamps it
  function automatic logic [12:0] clampf(input logic [12:0] f);
    return f < step_seq_pkg::STEP_FREQUENCY_MIN ? step_seq_pkg::STEP_FREQUENCY_MIN :
           f > step_seq_pkg::STEP_FREQUENCY_MAX ? step_seq_pkg::STEP_FREQUENCY_MAX : f;
  endfunction
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge sys_clk_i);
    reg_wr_i <= 1'b0;
  endtask
  task automatic rdr(input logic [7:0] a);
    @(posedge sys_clk_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge sys_clk_i);
    reg_rd_i <= 1'b0;
    #1 rd = reg_rdata_o;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e)
    begin
      failures++;
      $display("unexpected %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic pulse(input bit b);
    @(posedge sys_clk_i);
    if (b) fire_b <= 1'b1; else fire_a <= 1'b1;
    repeat (6) @(posedge sys_clk_i);
    fire_a <= 1'b0;
    fire_b <= 1'b0;
    repeat (10) @(posedge sys_clk_i);
    #1;
  endtask
  // Wait whole cycles, then step off the edge so outputs have settled
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk_i);
    #1;
  endtask
  task automatic print_verdict();
    if (failures == 0 && total_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    // About twice the scripted run, which is mostly step ticks
    repeat (40000) @(posedge sys_clk_i);
    failures++;
    print_verdict();
  end
  initial
  begin
    repeat (4) @(posedge sys_clk_i);
    arst_n_i <= 1'b1;
    cyc(3);
    chk("markers", 32'h0, 32'({m_hi, m_lo}));
    wr(step_seq_pkg::REG_CTRL, 32'h1 << step_seq_pkg::CMD_CLEAR);
    repeat (300) @(posedge sys_clk_i);
    wr(step_seq_pkg::REG_STEP_SEL, 32'h1);
    rdr(step_seq_pkg::REG_WORD0);
    chk("def step_frequency", 32'(step_seq_pkg::DEF_STEP_FREQUENCY), rd);
    rdr(step_seq_pkg::REG_WORD0 + 8'h08);
    chk("def dur", 32'(step_seq_pkg::DEF_DUR), rd);
    // Corners first, then random frequencies in the full field
    for (int i = 0; i < 6; i++)
    begin
      seed = xs(seed);
      frq = i == 0 ? 13'h0 : i == 1 ? 13'h1fff : seed[12:0];
      wr(step_seq_pkg::REG_WORD0, 32'(frq));
      rdr(step_seq_pkg::REG_WORD0);
      chk("step_frequency clamp", 32'(clampf(frq)), rd);
    end
    wr(step_seq_pkg::REG_WORD0 + 8'h08, 32'h0);
    rdr(step_seq_pkg::REG_WORD0 + 8'h08);
    chk("dur clamp", 32'(step_seq_pkg::DUR_MIN), rd);
    // Step 1: square, marker code 2, one tick, then idle
    frq = clampf(seed[12:0]);
    wr(step_seq_pkg::REG_WORD0,
       {5'h00, 2'h1, 1'b0, 2'h2, 2'h0, 5'h01, 2'h0, frq});
    wr(step_seq_pkg::REG_CTRL, 32'h1 << step_seq_pkg::CMD_START);
    cyc(6);
    chk("step_frequency out", 32'(frq), 32'(step_frequency_o));
    chk("wave", 32'h1, 32'(wave_o));
    chk("markers", 32'h2, 32'({m_hi, m_lo}));
    cyc(2600);
    chk("markers", 32'h0, 32'({m_hi, m_lo}));
    rdr(step_seq_pkg::REG_STATUS);
    chk("state", 32'h1, 32'(rd[14:8]));
    // Branch a to step 5 from a long step; zero branch b is ignored
    wr(step_seq_pkg::REG_WORD0 + 8'h08, 32'(step_seq_pkg::DUR_MAX));
    wr(step_seq_pkg::REG_WORD3, 32'h5 << step_seq_pkg::BRA_LSB);
    wr(step_seq_pkg::REG_STEP_SEL, 32'h5);
    wr(step_seq_pkg::REG_WORD0, 32'h0040_03e8);
    wr(step_seq_pkg::REG_CTRL, 32'h1 << step_seq_pkg::CMD_START);
    pulse(1'b1);
    chk("step", 32'h1, 32'(step_num_o));
    pulse(1'b0);
    chk("step", 32'h5, 32'(step_num_o));
    chk("markers", 32'h1, 32'({m_hi, m_lo}));
    wr(step_seq_pkg::REG_CTRL, 32'h1 << step_seq_pkg::CMD_STOP);
    cyc(4);
    chk("markers", 32'h0, 32'({m_hi, m_lo}));
    // Step 5 ramps over two ticks, carries the wave, then holds
    seed = xs(seed);
    ang = seed[11:0] % 12'he10;
    f2 = clampf(seed[28:16]);
    wr(step_seq_pkg::REG_WORD0,
       {5'h00, 2'h2, 1'b0, 2'h3, 2'h1, 5'h03, 2'h2, f2});
    wr(step_seq_pkg::REG_WORD0 + 8'h04, 32'(ang));
    wr(step_seq_pkg::REG_WORD0 + 8'h08, 32'h2);
    // Step 6 lasts one tick and jumps back to step 5 once
    wr(step_seq_pkg::REG_STEP_SEL, 32'h6);
    wr(step_seq_pkg::REG_WORD0 + 8'h08, 32'h1);
    wr(step_seq_pkg::REG_WORD3, 32'h0000_0105);
    wr(step_seq_pkg::REG_CTRL, 32'h1 << step_seq_pkg::CMD_START);
    cyc(4);
    wr(step_seq_pkg::REG_CTRL, 32'h1 << step_seq_pkg::CMD_BRB);
    cyc(2);
    chk("step", 32'h1, 32'(step_num_o));
    wr(step_seq_pkg::REG_CTRL, 32'h1 << step_seq_pkg::CMD_BRA);
    cyc(4);
    chk("step", 32'h5, 32'(step_num_o));
    chk("phase", 32'(ang) * 32'h000003e8, 32'(phase_o));
    chk("wave", 32'h1, 32'(wave_o));
    chk("markers", 32'h3, 32'({m_hi, m_lo}));
    cyc(5100);
    rdr(step_seq_pkg::REG_OUT_STEP_FREQUENCY);
    chk("ramp end", 32'(f2), rd);
    rdr(step_seq_pkg::REG_STATUS);
    chk("status", 32'h2006, 32'(rd[14:0]));
    wr(step_seq_pkg::REG_CTRL, 32'h1 << step_seq_pkg::CMD_START);
    cyc(4);
    wr(step_seq_pkg::REG_CTRL, 32'h1 << step_seq_pkg::CMD_HOLD);
    rdr(step_seq_pkg::REG_STATUS);
    chk("status", 32'h2006, 32'(rd[14:0]));
    chk("step_frequency out", 32'(step_seq_pkg::DEF_STEP_FREQUENCY), 32'(step_frequency_o));
    chk("markers", 32'h0, 32'({m_hi, m_lo}));
    wr(step_seq_pkg::REG_CTRL, 32'h1 << step_seq_pkg::CMD_START);
    cyc(2600);
    chk("step", 32'h5, 32'(step_num_o));
    cyc(5100);
    wr(step_seq_pkg::REG_CTRL, 32'h1 << step_seq_pkg::CMD_START);
    cyc(2600);
    chk("step", 32'h7, 32'(step_num_o));
    print_verdict();
  end
endmodule // tb_top
`default_nettype wire
